// File: verilog/brs_cfg_regs.sv
// boot-rom select extension and interrupt routing registers with ahb-lite slave
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module brs_cfg_regs
	import brs_pkg::*;
(
	// clock, reset and enable
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// host cycles watched for decode
	input  wire logic        cycValid,
	input  wire logic        cycMem,
	input  wire logic        cycIo,
	input  wire logic        cycWrite,
	input  wire logic [23:0] cycAddr,
	// pins from outside
	input  wire logic        float_error_in_n,
	input  wire logic        mouseIrqPin,
	input  wire logic        aux_buffer_full,
	// interrupt controller side
	input  wire logic        mouseEdgeMode,
	output logic             float_error_interrupt,
	output logic             mouse_interrupt,
	// chip select and bus clock
	output logic             boot_rom_select_n,
	output logic             busClk,
	output logic             busClkRise,
	// block interrupt
	output logic             irqOut
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] rom_select_extension;
	logic [7:0] bus_clock_divider_misc;
	logic [1:0] irqStatus;
	logic [1:0] irqMask;
	logic       auxLatch;
	logic       phaseWrite;
	logic [7:0] phaseIdx;
	logic [2:0] syncA;
	logic [2:0] syncB;
	logic       auxPrev;
	logic       floatPrev;

	// ----------------------------------------
	// address-phase decode
	// ----------------------------------------
	function automatic logic isReg(input logic [31:0] addr, input logic [7:0] idx);
		isReg = (addr == {22'h0, idx, 2'b00});
	endfunction : isReg

	wire        busActive;
	wire        takeWrite;
	wire        takeRead;
	wire        hitRom;
	wire        hitClk;
	wire        hitStat;
	wire        hitMask;
	wire        hitLive;
	wire [7:0]  readByte;
	wire [31:0] next_hrdata;

	assign busActive = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign takeWrite = busActive && hwrite;
	assign takeRead  = busActive && !hwrite;
	assign hitRom    = isReg(haddr, IDX_ROM_SEL);
	assign hitClk    = isReg(haddr, IDX_CLK_DIV);
	assign hitStat   = isReg(haddr, IDX_IRQ_STAT);
	assign hitMask   = isReg(haddr, IDX_IRQ_MASK);
	assign hitLive   = isReg(haddr, IDX_LIVE);
	assign readByte  = hitRom  ? rom_select_extension :
	                   hitClk  ? bus_clock_divider_misc :
	                   hitStat ? {6'h0, irqStatus} :
	                   hitMask ? {6'h0, irqMask} :
	                   hitLive ? {2'h0, irqOut, boot_rom_select_n, mouse_interrupt,
	                              float_error_interrupt, auxPrev, auxLatch} :
	                   8'h00;
	assign next_hrdata = takeRead ? {24'h000000, readByte} : 32'h00000000;

	// ----------------------------------------
	// data-phase write decode
	// ----------------------------------------
	wire       wrRom;
	wire       wrClk;
	wire       wrStat;
	wire       wrMask;
	wire [7:0] wByte;

	assign wByte  = hwdata[7:0];
	assign wrRom  = ce && phaseWrite && phaseIdx == IDX_ROM_SEL;
	assign wrClk  = ce && phaseWrite && phaseIdx == IDX_CLK_DIV;
	assign wrStat = ce && phaseWrite && phaseIdx == IDX_IRQ_STAT;
	assign wrMask = ce && phaseWrite && phaseIdx == IDX_IRQ_MASK;

	assign hreadyout = ce;
	assign hresp     = HRESP_OKAY;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phaseWrite <= 1'b0;
			phaseIdx   <= 8'h00;
			hrdata     <= 32'h00000000;
		end else if (ce) begin
			phaseWrite <= takeWrite && (hitRom || hitClk || hitStat || hitMask);
			phaseIdx   <= haddr[9:2];
			hrdata     <= next_hrdata;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rom_select_extension   <= RST_ROM_SEL;
			bus_clock_divider_misc <= RST_CLK_DIV;
			irqMask                <= RST_IRQ_MASK;
		end else begin
			if (wrRom)
				rom_select_extension <= wByte & WMASK_ROM;
			if (wrClk)
				bus_clock_divider_misc <= wByte & WMASK_CLK;
			if (wrMask)
				irqMask <= wByte[1:0];
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire floatErrSync;
	wire mousePinSync;
	wire auxFullSync;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			syncA <= 3'b001;
			syncB <= 3'b001;
		end else if (ce) begin
			syncA <= {aux_buffer_full, mouseIrqPin, float_error_in_n};
			syncB <= syncA;
		end
	end

	assign floatErrSync = !syncB[0];
	assign mousePinSync = syncB[1];
	assign auxFullSync  = syncB[2];

	// ----------------------------------------
	// boot-rom select decode
	// ----------------------------------------
	wire writeOk;
	wire inTop;
	wire inHighVideo;
	wire inLowVideo;
	wire romHit;
	wire next_romSelN;

	assign writeOk     = !cycWrite || rom_select_extension[ROM_WRITE_EN];
	assign inTop       = rom_select_extension[ROM_TOP_16M] &&
	                     cycAddr >= TOP_16M_LO && cycAddr <= TOP_16M_HI;
	assign inHighVideo = rom_select_extension[ROM_HIGH_VIDEO] &&
	                     cycAddr >= HIGH_VIDEO_LO && cycAddr <= HIGH_VIDEO_HI;
	assign inLowVideo  = rom_select_extension[ROM_LOW_VIDEO] &&
	                     cycAddr >= LOW_VIDEO_LO && cycAddr <= LOW_VIDEO_HI;
	assign romHit      = cycValid && cycMem && writeOk && (inTop || inHighVideo || inLowVideo);
	assign next_romSelN = !romHit;

	// ----------------------------------------
	// buffer-full latch and interrupt routing
	// ----------------------------------------
	wire latchMode;
	wire auxRise;
	wire floatRise;
	wire kbdPortRead;
	wire next_auxLatch;
	wire next_floatIrq;
	wire next_mouseIrq;

	assign latchMode   = bus_clock_divider_misc[CLK_AUX_LATCH];
	assign auxRise     = auxFullSync && !auxPrev;
	assign kbdPortRead = cycValid && cycIo && !cycWrite && cycAddr == KBD_DATA_PORT;
	assign next_auxLatch = kbdPortRead ? 1'b0 :
	                       (latchMode && auxRise) ? 1'b1 : auxLatch;
	assign next_floatIrq = bus_clock_divider_misc[CLK_FLOAT_EN] && floatErrSync;
	assign floatRise     = next_floatIrq && !floatPrev;
	assign next_mouseIrq = !latchMode     ? mousePinSync :
	                       mouseEdgeMode  ? auxLatch :
	                       (mousePinSync && !auxLatch);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			auxLatch              <= 1'b0;
			auxPrev               <= 1'b0;
			floatPrev             <= 1'b0;
			float_error_interrupt <= 1'b0;
			mouse_interrupt       <= 1'b0;
			boot_rom_select_n     <= 1'b1;
		end else if (ce) begin
			auxLatch              <= next_auxLatch;
			auxPrev               <= auxFullSync;
			floatPrev             <= next_floatIrq;
			float_error_interrupt <= next_floatIrq;
			mouse_interrupt       <= next_mouseIrq;
			boot_rom_select_n     <= next_romSelN;
		end
	end

	// ----------------------------------------
	// sticky status, mask and interrupt output
	// ----------------------------------------
	wire [1:0] events;
	wire [1:0] clearBits;
	wire [1:0] next_irqStatus;

	assign events         = {floatRise, latchMode && auxRise};
	assign clearBits      = wrStat ? wByte[1:0] : 2'b00;
	assign next_irqStatus = (irqStatus & ~clearBits) | events;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irqStatus <= 2'b00;
			irqOut    <= 1'b0;
		end else if (ce) begin
			irqStatus <= next_irqStatus;
			irqOut    <= |(next_irqStatus & irqMask);
		end
	end

	// ----------------------------------------
	// expansion bus clock
	// ----------------------------------------
	brs_clk_div u_clk_div (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.ce         (ce),
		.divSel     (bus_clock_divider_misc[CLK_DIV_LSB +: 3]),
		.busClk     (busClk),
		.busClkRise (busClkRise)
	);
endmodule : brs_cfg_regs

// File: verilog/brs_pkg.sv
// constants for the boot-rom select and interrupt routing registers
package brs_pkg;
	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [7:0]  IDX_ROM_SEL   = 8'h43;
	localparam logic [7:0]  IDX_CLK_DIV   = 8'h4d;
	localparam logic [7:0]  IDX_IRQ_STAT  = 8'h80;
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h81;
	localparam logic [7:0]  IDX_LIVE      = 8'h82;
	localparam logic [31:0] ADDR_ROM_SEL  = {22'h0, IDX_ROM_SEL, 2'b00};
	localparam logic [31:0] ADDR_CLK_DIV  = {22'h0, IDX_CLK_DIV, 2'b00};
	localparam logic [31:0] ADDR_IRQ_STAT = {22'h0, IDX_IRQ_STAT, 2'b00};
	localparam logic [31:0] ADDR_IRQ_MASK = {22'h0, IDX_IRQ_MASK, 2'b00};
	localparam logic [31:0] ADDR_LIVE     = {22'h0, IDX_LIVE, 2'b00};

	// ----------------------------------------
	// reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_ROM_SEL  = 8'h00;
	localparam logic [7:0] RST_CLK_DIV  = 8'h00;
	localparam logic [7:0] WMASK_ROM    = 8'h0f;
	localparam logic [7:0] WMASK_CLK    = 8'h3f;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ROM_LOW_VIDEO  = 0;
	localparam int ROM_HIGH_VIDEO = 1;
	localparam int ROM_TOP_16M    = 2;
	localparam int ROM_WRITE_EN   = 3;
	localparam int CLK_DIV_LSB    = 0;
	localparam int CLK_FLOAT_EN   = 5;
	localparam int CLK_AUX_LATCH  = 4;
	localparam int EV_AUX_FULL    = 0;
	localparam int EV_FLOAT_ERR   = 1;

	// ----------------------------------------
	// decode windows
	// ----------------------------------------
	localparam logic [23:0] TOP_16M_LO    = 24'hff0000;
	localparam logic [23:0] TOP_16M_HI    = 24'hffffff;
	localparam logic [23:0] HIGH_VIDEO_LO = 24'h0c4000;
	localparam logic [23:0] HIGH_VIDEO_HI = 24'h0c7fff;
	localparam logic [23:0] LOW_VIDEO_LO  = 24'h0c0000;
	localparam logic [23:0] LOW_VIDEO_HI  = 24'h0c3fff;
	localparam logic [23:0] KBD_DATA_PORT = 24'h000060;

	// ----------------------------------------
	// divisor codes and counts
	// ----------------------------------------
	typedef enum logic [2:0] {
		BRS_DIV_BY4 = 3'b000,
		BRS_DIV_BY3 = 3'b001
	} brs_div_t;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [1:0] DIV3_LAST = 2'h2;

	// ----------------------------------------
	// ahb-lite codes
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic       HRESP_OKAY    = 1'b0;
endpackage : brs_pkg

// File: verilog/brs_clk_div.sv
// expansion bus clock divider steered by the divisor field
`timescale 1ns/1ps
module brs_clk_div
	import brs_pkg::*;
(
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       ce,
	// divisor code
	input  wire logic [2:0] divSel,
	// divided clock
	output logic            busClk,
	output logic            busClkRise
);
	logic [1:0] count;
	wire  [1:0] lastCount;
	wire        wrap;
	wire  [1:0] next_count;
	wire        next_busClk;

	// ----------------------------------------
	// divide by 4 for code 000 and the reserved codes, by 3 for code 001
	// ----------------------------------------
	assign lastCount   = (divSel == BRS_DIV_BY3) ? DIV3_LAST : DIV4_LAST;
	assign wrap        = (count >= lastCount);
	assign next_count  = wrap ? 2'h0 : 2'(count + 2'h1);
	assign next_busClk = (next_count == 2'h0);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count      <= 2'h0;
			busClk     <= 1'b0;
			busClkRise <= 1'b0;
		end else if (ce) begin
			count      <= next_count;
			busClk     <= next_busClk | (next_count == 2'h1 && lastCount == DIV4_LAST);
			busClkRise <= next_busClk;
		end
	end
endmodule : brs_clk_div

// File: sim/brs_cfg_regs_assertions.sv
// concurrent checks on the boot-rom select and interrupt routing ports
`timescale 1ns/1ps
module brs_cfg_regs_checker
	import brs_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        ce,
	// register bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	// host cycles and pins
	input wire logic        cycValid,
	input wire logic        cycMem,
	input wire logic        cycIo,
	input wire logic [23:0] cycAddr,
	input wire logic        float_error_in_n,
	input wire logic        mouseIrqPin,
	input wire logic        mouseEdgeMode,
	// outputs
	input wire logic        float_error_interrupt,
	input wire logic        mouse_interrupt,
	input wire logic        boot_rom_select_n,
	input wire logic        busClkRise
);
	logic inWin;
	logic rdReq;
	assign inWin = (cycAddr >= LOW_VIDEO_LO && cycAddr <= HIGH_VIDEO_HI) || cycAddr >= TOP_16M_LO;
	assign rdReq = hsel && hready && htrans[1] && !hwrite && ce;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_no_rom;
		!(cycValid && cycMem && inWin);
	endsequence
	sequence s_no_read;
		!rdReq;
	endsequence
	a_ready_ce: assert property (hreadyout == ce)
		else $error("ready differs from enable");
	a_rdata_idle: assert property (s_no_read |=> hrdata == 32'h00000000)
		else $error("read data without a read");
	a_sel_outside: assert property (s_no_rom |=> boot_rom_select_n)
		else $error("rom select outside its windows");
	a_sel_io: assert property (cycValid && cycIo |=> boot_rom_select_n)
		else $error("rom select on an io cycle");
	a_float_pin: assert property (float_error_interrupt |-> !$past(float_error_in_n, 3))
		else $error("float interrupt without its pin");
	a_mouse_pin: assert property (!mouseEdgeMode && mouse_interrupt |-> $past(mouseIrqPin, 3))
		else $error("mouse line high without its pin");
	a_rise_single: assert property (busClkRise |=> !busClkRise)
		else $error("bus clock rise longer than one cycle");
	a_rise_gap: assert property (busClkRise ##1 busClkRise |-> 1'b0)
		else $error("two bus clock rises back to back");
endmodule : brs_cfg_regs_checker

bind brs_cfg_regs brs_cfg_regs_checker chk_u (
	.clk_sys(clk_sys), .reset(reset), .ce(ce), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.cycValid(cycValid), .cycMem(cycMem), .cycIo(cycIo), .cycAddr(cycAddr),
	.float_error_in_n(float_error_in_n), .mouseIrqPin(mouseIrqPin),
	.mouseEdgeMode(mouseEdgeMode), .float_error_interrupt(float_error_interrupt),
	.mouse_interrupt(mouse_interrupt), .boot_rom_select_n(boot_rom_select_n),
	.busClkRise(busClkRise)
);

// File: sim/brs_pic_model.sv
// interrupt controller stand-in: trigger mode and rise counter
`timescale 1ns/1ps
module brs_pic_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// trigger mode chosen by the bench
	input  wire logic       edgeSel,
	output logic            mouseEdgeMode,
	// mouse line seen by the controller
	input  wire logic       mouse_interrupt,
	output logic [7:0]      riseCount
);
	logic lastLine;
	assign mouseEdgeMode = edgeSel;
	always_ff @(posedge clk_sys) begin
		lastLine <= mouse_interrupt;
		if (reset) riseCount <= 8'h00;
		else if (mouse_interrupt && !lastLine) riseCount <= riseCount + 8'h01;
	end
endmodule : brs_pic_model

// File: sim/testbench.sv
// self-checking bench for the boot-rom select and interrupt routing block
`timescale 1ns/1ps
module testbench import brs_pkg::*;;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk_sys = 1'h0, reset = 1'h1, ce = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	logic        cycValid = 1'h0, cycMem = 1'h0, cycIo = 1'h0, cycWrite = 1'h0;
	logic        float_error_in_n = 1'h1, mouseIrqPin = 1'h0, aux_buffer_full = 1'h0;
	logic        edgeSel = 1'h0, hreadyout, hresp, float_error_interrupt, mouse_interrupt;
	logic        boot_rom_select_n, busClk, busClkRise, irqOut, mouseEdgeMode;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  riseCount;
	logic [23:0] cycAddr = 24'h000000;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	int          num_errors = 0, n_compared = 0, n, h;
	logic [31:0] tbl [17] = '{32'h120c0000, 32'h120c3fff, 32'h100c4000, 32'h140c0000,
		32'h960c3fff, 32'h980c0000, 32'h220c4000, 32'h220c7fff, 32'h200c8000, 32'ha60c7fff,
		32'h42ff0000, 32'h40feffff, 32'hc6ffffff, 32'h44ff0000, 32'h30ff0000, 32'h000c0000,
		32'h840c0000};
	logic [31:0] portTbl [4] = '{32'h00000060, 32'h08001060, 32'h08000061, 32'h0c000060};

	brs_cfg_regs dut_u (
		.clk_sys               (clk_sys),
		.reset                 (reset),
		.ce                    (ce),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hsize                 (hsize),
		.hwdata                (hwdata),
		.hready                (hreadyout),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.hrdata                (hrdata),
		.cycValid              (cycValid),
		.cycMem                (cycMem),
		.cycIo                 (cycIo),
		.cycWrite              (cycWrite),
		.cycAddr               (cycAddr),
		.float_error_in_n      (float_error_in_n),
		.mouseIrqPin           (mouseIrqPin),
		.aux_buffer_full       (aux_buffer_full),
		.mouseEdgeMode         (mouseEdgeMode),
		.float_error_interrupt (float_error_interrupt),
		.mouse_interrupt       (mouse_interrupt),
		.boot_rom_select_n     (boot_rom_select_n),
		.busClk                (busClk),
		.busClkRise            (busClkRise),
		.irqOut                (irqOut)
	);
	brs_pic_model pic_u (
		.clk_sys         (clk_sys),
		.reset           (reset),
		.edgeSel         (edgeSel),
		.mouseEdgeMode   (mouseEdgeMode),
		.mouse_interrupt (mouse_interrupt),
		.riseCount       (riseCount)
	);

	always #20 clk_sys = ~clk_sys;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask : bus
	task rd(input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		check(q, exp);
		check(hresp, HRESP_OKAY);
	endtask : rd
	task cyc(input logic [31:0] e);
		cycValid <= 1'h1; cycIo <= e[27]; cycMem <= !e[27]; cycWrite <= e[26];
		cycAddr <= e[23:0];
		@(posedge clk_sys);
		cycValid <= 1'h0;
		@(posedge clk_sys);
		check(boot_rom_select_n, !e[25]);
	endtask : cyc
	task w8;
		repeat (8) @(posedge clk_sys);
	endtask : w8
	task cnt(input logic [31:0] exp, input logic [31:0] expHigh);
		n = 0;
		h = 0;
		repeat (12) begin
			@(posedge clk_sys);
			n += busClkRise;
			h += busClk;
		end
		check(n, exp);
		check(h, expHigh);
	endtask : cnt
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'h0;
		@(posedge clk_sys);
		rd(ADDR_ROM_SEL, 32'h0);
		rd(ADDR_CLK_DIV, 32'h0);
		rd(32'h00000300, 32'h0);
		bus(1'h1, ADDR_ROM_SEL, 32'hff);
		rd(ADDR_ROM_SEL, 32'h0f);
		bus(1'h1, ADDR_CLK_DIV, 32'hff);
		rd(ADDR_CLK_DIV, 32'h3f);
		bus(1'h1, ADDR_CLK_DIV, 32'h0);
		foreach (tbl[i]) begin
			bus(1'h1, ADDR_ROM_SEL, tbl[i] >> 28);
			cyc(tbl[i]);
		end
		float_error_in_n <= 1'h0; w8; check(float_error_interrupt, 1'h0);
		bus(1'h1, ADDR_CLK_DIV, 32'h20); w8; check(float_error_interrupt, 1'h1);
		float_error_in_n <= 1'h1; w8; check(float_error_interrupt, 1'h0);
		mouseIrqPin <= 1'h1; aux_buffer_full <= 1'h1; w8; check(mouse_interrupt, 1'h1);
		mouseIrqPin <= 1'h0; w8; check(mouse_interrupt, 1'h0);
		aux_buffer_full <= 1'h0; bus(1'h1, ADDR_IRQ_STAT, 32'h3); bus(1'h1, ADDR_IRQ_MASK, 32'h1);
		rd(ADDR_IRQ_STAT, 32'h0);
		edgeSel <= 1'h1; bus(1'h1, ADDR_CLK_DIV, 32'h10);
		mouseIrqPin <= 1'h1; w8; check(mouse_interrupt, 1'h0);
		aux_buffer_full <= 1'h1; w8; check(mouse_interrupt, 1'h1);
		check(riseCount, 32'h2);
		check(irqOut, 1'h1);
		rd(ADDR_LIVE, 32'h3b);
		mouseIrqPin <= 1'h0; w8; check(mouse_interrupt, 1'h1);
		rd(ADDR_IRQ_STAT, 32'h1);
		bus(1'h1, ADDR_IRQ_STAT, 32'h1); w8; check(irqOut, 1'h0);
		foreach (portTbl[i]) cyc(portTbl[i]);
		w8; check(mouse_interrupt, 1'h1);
		cyc(32'h08000060); w8; check(mouse_interrupt, 1'h0);
		edgeSel <= 1'h0; mouseIrqPin <= 1'h1; w8; check(mouse_interrupt, 1'h1);
		aux_buffer_full <= 1'h0; w8;
		aux_buffer_full <= 1'h1; w8; check(mouse_interrupt, 1'h0);
		check(irqOut, 1'h1);
		bus(1'h1, ADDR_IRQ_MASK, 32'h0); w8; check(irqOut, 1'h0);
		cyc(32'h08000060); w8; check(mouse_interrupt, 1'h1);
		bus(1'h1, ADDR_CLK_DIV, 32'h0); w8; cnt(32'h3, 32'h6);
		bus(1'h1, ADDR_CLK_DIV, 32'h1); w8; cnt(32'h4, 32'h4);
		bus(1'h1, ADDR_CLK_DIV, 32'h7); w8; cnt(32'h3, 32'h6);
		give_verdict;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		give_verdict;
	end
endmodule : testbench
